// ### src/drrl_pkg.sv
// Package with the constants, register map and types of the drive reset request logic.
package drrl_pkg;

    // ========================================================================
    // Register port, terminal and selector widths.
    // ========================================================================
    localparam int ADDR_W = 4;  // Word address width of the register port.
    localparam int DATA_W = 16;  // Data width of the register port.
    localparam int DIN_W = 4;  // Number of programmable digital input terminals.
    localparam int SEL_W = 2;  // Width of the digital input route selector.

    // ========================================================================
    // Register offsets (word addresses).
    // ========================================================================
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;  // Key and sequencing configuration.
    localparam logic [ADDR_W-1:0] OFS_RST_PARAM = 4'h1;  // Reset request parameter.
    localparam logic [ADDR_W-1:0] OFS_DIN_ROUTE = 4'h2;  // Digital input routing.
    localparam logic [ADDR_W-1:0] OFS_USER_TRIP = 4'h3;  // User trip parameter.
    localparam logic [ADDR_W-1:0] OFS_TYPE = 4'h4;  // Drive type, pending write, active read.
    localparam logic [ADDR_W-1:0] OFS_PARAM = 4'h5;  // Reset-dependent parameter.
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h6;  // Live drive state.
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h7;  // Sticky event bits, read only.
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 4'h8;  // Interrupt enables.
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 4'h9;  // Write one to clear, write only.

    // ========================================================================
    // Field positions.
    // ========================================================================
    localparam int CTRL_STOP_OFF = 0;  // Stop function of the stop/reset key inoperative.
    localparam int CTRL_LATCHING = 1;  // Latching sequencing mode selected.
    localparam int CTRL_AUTO_RST = 2;  // Auto-restart enabled.
    localparam int ROUTE_EN = 4;  // Digital input drives the reset request parameter.
    localparam int ST_TRIPPED = 0;  // Status: drive tripped.
    localparam int ST_RUN_LATCH = 1;  // Status: run latch set.
    localparam int ST_RUNNING = 2;  // Status: motor running.
    localparam int IRQ_W = 3;  // Number of interrupt events.
    localparam int EV_RESET = 0;  // Event: a drive reset was performed.
    localparam int EV_TRIP = 1;  // Event: the drive tripped.
    localparam int EV_LATCH_CLR = 2;  // Event: keypad reset cleared the run latch.

    // ========================================================================
    // Codes and reset values.
    // ========================================================================
    localparam logic [DATA_W-1:0] USER_TRIP_RESET_CODE = 16'h0064;  // Value 100 asks a reset.
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;  // Reset value of every word.

    // Trip condition of the drive.
    typedef enum logic {
        DRRL_HEALTHY,
        DRRL_TRIPPED
    } drrl_trip_t;

endpackage

// ### src/drrl_sync2.sv
// Two flip-flop synchroniser for a bundle of pin levels.
module drrl_sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Levels.
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    // Both stages; the first is read only by the second.
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } drrl_sync_t;

    drrl_sync_t s_reg;  // Registered stages.
    drrl_sync_t s_next;  // Next value of the stages.

    // Shift the pin levels through the two stages.
    always_comb begin
        s_next.meta = i_async;
        s_next.stable = s_reg.meta;
    end

    // Registers clear to zero under reset.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_sync = s_reg.stable;

endmodule

// ### src/drrl_rise.sv
// Rising edge detector giving a one-cycle pulse on each 0 to 1 transition.
module drrl_rise (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Level in, pulse out.
    input wire logic i_level,
    output logic o_pulse
);

    // Previous level only.
    typedef struct packed {
        logic prev;
    } drrl_rise_t;

    drrl_rise_t r_reg;  // Registered previous level.
    drrl_rise_t r_next;  // Next previous level.

    // Remember the level so that a steady high gives no new pulse.
    always_comb begin
        r_next.prev = i_level;
    end

    // A high level seen right after reset counts as an edge, which is safe here.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_pulse = i_level & ~r_reg.prev;

endmodule

// ### src/drrl_top.sv
// Top of the drive reset request logic: request sources, trip, run latch and registers.
//
// Chosen here: the register offsets and the plain strobed port.

module drrl_top (
    // Clock and reset.
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    // Register port.
    input wire logic [drrl_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [drrl_pkg::DATA_W-1:0] I_WR_DATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [drrl_pkg::DATA_W-1:0] O_RD_DATA,
    // Keypad and terminal pins, asynchronous.
    input wire logic I_STOP_KEY,
    input wire logic I_RUN_KEY,
    input wire logic I_RUN_FWD,
    input wire logic I_RUN_REV,
    input wire logic [drrl_pkg::DIN_W-1:0] I_DIN,
    // Drive core, same clock.
    input wire logic I_TRIP_SET,
    input wire logic I_RUN_LATCH_SET,
    input wire logic I_MOTOR_RUNNING,
    // Drive core commands.
    output logic O_STOP_CMD,
    output logic O_RESET_PULSE,
    output logic O_RESET_FROM_KEYPAD,
    output logic O_COMMIT_PARAMS,
    output logic O_SAVE_START,
    output logic O_AUTO_RESTART,
    output logic O_TRIPPED,
    output logic O_RUN_LATCH,
    output logic [drrl_pkg::DATA_W-1:0] O_DRIVE_TYPE,
    output logic [drrl_pkg::DATA_W-1:0] O_PARAM_ACTIVE,
    // Interrupt.
    output logic O_IRQ
);
    import drrl_pkg::*;

    // ========================================================================
    // State of the block.
    // ========================================================================
    typedef struct packed {
        logic stop_off;  // Stop function of the key inoperative.
        logic latching;  // Latching sequencing mode.
        logic auto_rst;  // Auto-restart enabled.
        logic rst_param;  // Reset request parameter written by software.
        logic route_en;  // Route a terminal to the reset parameter.
        logic [SEL_W-1:0] route_sel;  // Which terminal is routed.
        logic [DATA_W-1:0] type_pend;  // Drive type waiting for a reset.
        logic [DATA_W-1:0] type_act;  // Drive type in effect.
        logic [DATA_W-1:0] par_pend;  // Parameter value waiting for a reset.
        logic [DATA_W-1:0] par_act;  // Parameter value in effect.
        drrl_trip_t trip;  // Trip condition.
        logic run_latch;  // Sequencer run latch.
        logic rst_pulse;  // Merged single-cycle reset pulse.
        logic rst_keypad;  // The pulse came from the keypad.
        logic commit;  // Commit pulse to the parameter store.
        logic save;  // Save start pulse to the nonvolatile store.
        logic restart;  // Automatic restart pulse.
        logic stop_cmd;  // Stop command pulse.
        logic [IRQ_W-1:0] irq_stat;  // Sticky event bits.
        logic [IRQ_W-1:0] irq_en;  // Interrupt enables.
        logic [DATA_W-1:0] rd_data;  // Read data for the cycle after a read.
    } drrl_state_t;

    drrl_state_t st_reg;  // Registered state.
    drrl_state_t st_next;  // Next state.

    // ========================================================================
    // Pin synchronisers and edge detection.
    // ========================================================================
    logic [DIN_W+3:0] pins_sync;  // Synchronised pins.
    logic stop_sync;  // Stop/reset key level.
    logic run_key_sync;  // Run key level.
    logic fwd_sync;  // Run forward input level.
    logic rev_sync;  // Run reverse input level.
    logic [DIN_W-1:0] din_sync;  // Terminal levels.
    logic key_press;  // Stop/reset key pressed this cycle.
    logic param_level;  // Combined reset request parameter level.
    logic param_rise;  // Rising edge of the reset request parameter.

    // All pins share one synchroniser so they stay aligned with each other.
    drrl_sync2 #(
        .W(DIN_W + 4)
    ) u_sync (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .i_async({I_DIN, I_RUN_REV, I_RUN_FWD, I_RUN_KEY, I_STOP_KEY}),
        .o_sync(pins_sync)
    );

    assign stop_sync = pins_sync[0];
    assign run_key_sync = pins_sync[1];
    assign fwd_sync = pins_sync[2];
    assign rev_sync = pins_sync[3];
    assign din_sync = pins_sync[DIN_W+3:4];

    // Key press is a rising edge so holding the key gives one request only.
    drrl_rise u_key_rise (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .i_level(stop_sync),
        .o_pulse(key_press)
    );

    // The routed terminal and the software bit both drive the parameter.
    assign param_level = st_reg.rst_param | (st_reg.route_en & din_sync[st_reg.route_sel]);

    // Only a 0 to 1 transition asks for a reset; a steady high does not repeat.
    drrl_rise u_param_rise (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .i_level(param_level),
        .o_pulse(param_rise)
    );

    // ========================================================================
    // Request decode.
    // ========================================================================
    logic keypad_req;  // Keypad asks for a reset.
    logic serial_req;  // Serial host asks for a reset.
    logic any_req;  // Any source asks for a reset.
    logic latch_qual;  // Keypad reset may clear the run latch.
    logic latch_clr;  // Run latch is cleared by the current reset pulse.
    logic wr_hit;  // Register write strobe.

    // Stopped drive: always reset; running: reset only if stop is off or run is held.
    assign keypad_req = key_press & (~I_MOTOR_RUNNING | st_reg.stop_off | run_key_sync);
    assign wr_hit = I_WR;
    assign serial_req = wr_hit && I_ADDR == OFS_USER_TRIP && I_WR_DATA == USER_TRIP_RESET_CODE;
    assign any_req = keypad_req | param_rise | serial_req;

    // The run latch condition is judged when the pulse acts, with live inputs.
    assign latch_qual = st_reg.trip == DRRL_TRIPPED && st_reg.latching && !fwd_sync
        && !rev_sync && st_reg.auto_rst;
    assign latch_clr = st_reg.rst_pulse & st_reg.rst_keypad & latch_qual;

    // ========================================================================
    // Next state.
    // ========================================================================
    // One process computes every next value; register writes, then hardware effects.
    always_comb begin
        st_next = st_reg;
        // Pulses last one cycle unless raised again below.
        st_next.commit = 1'b0;
        st_next.save = 1'b0;
        st_next.restart = 1'b0;

        // Merge the sources into one pulse and record whether the keypad asked.
        st_next.rst_pulse = any_req;
        st_next.rst_keypad = keypad_req;

        // Stop the drive only when the key stops and the run key is not held.
        st_next.stop_cmd = key_press & I_MOTOR_RUNNING & ~st_reg.stop_off & ~run_key_sync;

        // Software writes.
        if (wr_hit) begin
            unique case (I_ADDR)
                OFS_CTRL: begin
                    st_next.stop_off = I_WR_DATA[CTRL_STOP_OFF];
                    st_next.latching = I_WR_DATA[CTRL_LATCHING];
                    st_next.auto_rst = I_WR_DATA[CTRL_AUTO_RST];
                end
                OFS_RST_PARAM: begin
                    st_next.rst_param = I_WR_DATA[0];
                end
                OFS_DIN_ROUTE: begin
                    st_next.route_sel = I_WR_DATA[SEL_W-1:0];
                    st_next.route_en = I_WR_DATA[ROUTE_EN];
                end
                OFS_TYPE: begin
                    // The new type waits; the active type changes only at reset.
                    st_next.type_pend = I_WR_DATA;
                end
                OFS_PARAM: begin
                    st_next.par_pend = I_WR_DATA;
                end
                OFS_IRQ_EN: begin
                    st_next.irq_en = I_WR_DATA[IRQ_W-1:0];
                end
                OFS_IRQ_CLR: begin
                    st_next.irq_stat = st_reg.irq_stat & ~I_WR_DATA[IRQ_W-1:0];
                end
                default: begin
                    // Unmapped and read-only words ignore writes.
                end
            endcase
        end

        // Effects of the merged reset pulse, allowed whether or not the motor runs.
        if (st_reg.rst_pulse) begin
            st_next.type_act = st_reg.type_pend;
            st_next.par_act = st_reg.par_pend;
            st_next.commit = 1'b1;
            st_next.save = 1'b1;
            st_next.irq_stat[EV_RESET] = 1'b1;
            if (st_reg.trip == DRRL_TRIPPED) begin
                st_next.trip = DRRL_HEALTHY;
                // Restart only if the latch survives this reset.
                st_next.restart = st_reg.auto_rst & st_reg.run_latch & ~latch_clr;
            end
            if (latch_clr) begin
                st_next.run_latch = 1'b0;
                st_next.irq_stat[EV_LATCH_CLR] = 1'b1;
            end
        end

        // A run command after the clear still sets the latch in the same cycle.
        if (I_RUN_LATCH_SET) begin
            st_next.run_latch = 1'b1;
        end

        // A new trip wins over a reset that lands in the same cycle.
        if (I_TRIP_SET) begin
            st_next.trip = DRRL_TRIPPED;
            st_next.restart = 1'b0;
            st_next.irq_stat[EV_TRIP] = 1'b1;
        end

        // Read data for the cycle after the read strobe; unmapped words read zero.
        st_next.rd_data = ZERO_WORD;
        if (I_RD) begin
            unique case (I_ADDR)
                OFS_CTRL: begin
                    st_next.rd_data[CTRL_STOP_OFF] = st_reg.stop_off;
                    st_next.rd_data[CTRL_LATCHING] = st_reg.latching;
                    st_next.rd_data[CTRL_AUTO_RST] = st_reg.auto_rst;
                end
                OFS_RST_PARAM: begin
                    st_next.rd_data[0] = st_reg.rst_param;
                end
                OFS_DIN_ROUTE: begin
                    st_next.rd_data[SEL_W-1:0] = st_reg.route_sel;
                    st_next.rd_data[ROUTE_EN] = st_reg.route_en;
                end
                OFS_TYPE: begin
                    st_next.rd_data = st_reg.type_act;
                end
                OFS_PARAM: begin
                    st_next.rd_data = st_reg.par_act;
                end
                OFS_STATUS: begin
                    st_next.rd_data[ST_TRIPPED] = st_reg.trip == DRRL_TRIPPED;
                    st_next.rd_data[ST_RUN_LATCH] = st_reg.run_latch;
                    st_next.rd_data[ST_RUNNING] = I_MOTOR_RUNNING;
                end
                OFS_IRQ_STAT: begin
                    st_next.rd_data[IRQ_W-1:0] = st_reg.irq_stat;
                end
                OFS_IRQ_EN: begin
                    st_next.rd_data[IRQ_W-1:0] = st_reg.irq_en;
                end
                default: begin
                    // User trip and clear words are write only and read zero.
                end
            endcase
        end
    end

    // ========================================================================
    // State register.
    // ========================================================================
    // Everything clears under reset; the drive starts healthy with no latch.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================================================
    // Outputs.
    // ========================================================================
    assign O_RD_DATA = st_reg.rd_data;
    assign O_STOP_CMD = st_reg.stop_cmd;
    assign O_RESET_PULSE = st_reg.rst_pulse;
    assign O_RESET_FROM_KEYPAD = st_reg.rst_keypad;
    assign O_COMMIT_PARAMS = st_reg.commit;
    assign O_SAVE_START = st_reg.save;
    assign O_AUTO_RESTART = st_reg.restart;
    assign O_TRIPPED = st_reg.trip == DRRL_TRIPPED;
    assign O_RUN_LATCH = st_reg.run_latch;
    assign O_DRIVE_TYPE = st_reg.type_act;
    assign O_PARAM_ACTIVE = st_reg.par_act;
    // Level interrupt, high while any enabled sticky bit is set.
    assign O_IRQ = |(st_reg.irq_stat & st_reg.irq_en);

    // ========================================================================
    // Checks.
    // ========================================================================
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);

    // A reset pulse followed one cycle later by its side effects.
    sequence s_reset_pulse;
        O_RESET_PULSE && !I_TRIP_SET;
    endsequence
    sequence s_effects;
        O_COMMIT_PARAMS && O_SAVE_START && !O_TRIPPED;
    endsequence

    chk_trip_cleared: assert property (s_reset_pulse |=> s_effects)
        else $error("reset pulse did not clear trip and start commit and save");
    chk_type_applied: assert property (O_RESET_PULSE |=> O_DRIVE_TYPE == $past(st_reg.type_pend))
        else $error("drive type not applied at reset");
    chk_type_held: assert property (!O_RESET_PULSE |=> $stable(O_DRIVE_TYPE))
        else $error("drive type changed without a reset");
    // The press must turn into a reset, never into a stop, whatever the motor does.
    chk_stop_inop: assert property (key_press && st_reg.stop_off
        |=> O_RESET_PULSE && !O_STOP_CMD)
        else $error("inoperative stop key stopped the drive or gave no reset");
    chk_key_reset: assert property (key_press && (!I_MOTOR_RUNNING || run_key_sync)
        |=> O_RESET_PULSE && O_RESET_FROM_KEYPAD && !O_STOP_CMD)
        else $error("key press did not give a keypad reset");
    // A pulse after a steady high level must come from another source.
    chk_param_edge: assert property (param_level [*2]
        |=> !O_RESET_PULSE || $past(keypad_req) || $past(serial_req))
        else $error("steady reset parameter repeated a reset");
    // A keypad press in the same cycle would rightly mark the merged pulse as keypad.
    chk_serial_reset: assert property (serial_req && !keypad_req
        |=> O_RESET_PULSE && !O_RESET_FROM_KEYPAD)
        else $error("user trip code did not request a reset");
    chk_latch_clear: assert property (O_RESET_PULSE && O_RESET_FROM_KEYPAD && latch_qual
        && !I_RUN_LATCH_SET |=> !O_RUN_LATCH && !O_AUTO_RESTART)
        else $error("qualified keypad reset left the run latch or restarted");
    chk_latch_kept: assert property (O_RESET_PULSE && !O_RESET_FROM_KEYPAD && O_RUN_LATCH
        |=> O_RUN_LATCH)
        else $error("non keypad reset cleared the run latch");
    chk_one_pulse: assert property (any_req |=> O_RESET_PULSE ##1 !O_RESET_PULSE || $past(any_req, 1))
        else $error("reset pulse longer than its request");

endmodule

// ### tb/drrl_panel_model.sv
// Keypad and terminal block model driving the pin side of the reset logic.
module drrl_panel_model
    import drrl_pkg::*;
(
    // Clock used to pace key presses.
    input wire logic i_clk,
    // Pins towards the drive.
    output logic o_stop_key,
    output logic o_run_key,
    output logic o_fwd,
    output logic o_rev,
    output logic [DIN_W-1:0] o_din
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // All pins idle low at time zero.
    initial begin
        {o_stop_key, o_run_key, o_fwd, o_rev, o_din} = '0;
    end
    // A press lasts long enough to cross the two-stage synchroniser.
    task automatic press(input logic hold_run);
        @(posedge i_clk);
        o_run_key <= hold_run;
        o_stop_key <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_stop_key <= 1'b0;
        o_run_key <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask
    // Terminal levels change at an edge, like a slow field wire.
    task automatic set_pins(input logic f, input logic r, input logic [DIN_W-1:0] d);
        @(posedge i_clk);
        o_fwd <= f;
        o_rev <= r;
        o_din <= d;
    endtask
endmodule

// ### tb/drrl_top_tb_top.sv
// Bench top: register and pin scenarios for the drive reset request logic.
module drrl_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import drrl_pkg::*;
    // ========================================
    // Stimulus and observed signals.
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0, rd = 1'b0, trip = 1'b0, latch = 1'b0, running = 1'b0;
    logic stop_key, run_key, fwd, rev, stop_cmd, rst_p, kp, commit, save, auto_r;
    logic tripped, run_l, irq, last_kp;
    logic [DIN_W-1:0] din;
    logic [DATA_W-1:0] rdata, dtype, pact;
    int err_count = 0, n_tests = 0, n_rst = 0, n_stop = 0, n_ar = 0;
    always #2.5 clk = ~clk;
    drrl_top drrl_top_inst (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
        .I_WR_DATA(wdata), .I_WR(wr), .I_RD(rd), .O_RD_DATA(rdata),
        .I_STOP_KEY(stop_key), .I_RUN_KEY(run_key), .I_RUN_FWD(fwd), .I_RUN_REV(rev),
        .I_DIN(din), .I_TRIP_SET(trip), .I_RUN_LATCH_SET(latch),
        .I_MOTOR_RUNNING(running), .O_STOP_CMD(stop_cmd), .O_RESET_PULSE(rst_p),
        .O_RESET_FROM_KEYPAD(kp), .O_COMMIT_PARAMS(commit), .O_SAVE_START(save),
        .O_AUTO_RESTART(auto_r), .O_TRIPPED(tripped), .O_RUN_LATCH(run_l),
        .O_DRIVE_TYPE(dtype), .O_PARAM_ACTIVE(pact), .O_IRQ(irq));
    drrl_panel_model drrl_panel_model_inst (.i_clk(clk), .o_stop_key(stop_key),
        .o_run_key(run_key), .o_fwd(fwd), .o_rev(rev), .o_din(din));
    // Pulses are tallied so a missing or doubled one shows in the counts.
    always @(posedge clk) begin
        if (rst_p === 1'b1) begin
            n_rst++;
            last_kp <= kp;
        end
        if (stop_cmd === 1'b1) n_stop++;
        if (auto_r === 1'b1) n_ar++;
    end
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic core(input logic t, input logic l);
        @(posedge clk);
        trip <= t;
        latch <= l;
        @(posedge clk);
        trip <= 1'b0;
        latch <= 1'b0;
        #1;
    endtask
    task automatic wrap_up();
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(OFS_STATUS, ZERO_WORD);
        rd_reg(4'hF, ZERO_WORD);
        wr_reg(OFS_TYPE, 16'h0005);
        wr_reg(OFS_PARAM, 16'h0007);
        wr_reg(OFS_CTRL, 16'h0006);
        wr_reg(OFS_IRQ_EN, 16'h0001);
        running <= 1'b1;
        core(1'b1, 1'b1);
        chk(dtype, ZERO_WORD);
        rd_reg(OFS_STATUS, 16'h0007);
        wr_reg(OFS_USER_TRIP, 16'h0063);
        wr_reg(OFS_USER_TRIP, USER_TRIP_RESET_CODE);
        #1;
        chk({rst_p, kp}, 16'h0002);
        @(posedge clk);
        #1;
        chk({commit, save, auto_r, tripped, run_l}, 16'h001D);
        chk(dtype, 16'h0005);
        chk(pact, 16'h0007);
        rd_reg(OFS_TYPE, 16'h0005);
        chk({irq, 15'(n_rst)}, 16'h8001);
        wr_reg(OFS_IRQ_CLR, 16'h0001);
        #1;
        chk(irq, 16'h0000);
        wr_reg(OFS_RST_PARAM, 16'h0001);
        wr_reg(OFS_RST_PARAM, 16'h0001);
        wr_reg(OFS_RST_PARAM, 16'h0000);
        chk(16'(n_rst), 16'h0002);
        wr_reg(OFS_DIN_ROUTE, 16'h0012);
        drrl_panel_model_inst.set_pins(1'b0, 1'b0, 4'h4);
        repeat (8) @(posedge clk);
        chk({last_kp, 15'(n_rst)}, 16'h0003);
        @(posedge clk) running <= 1'b0;
        drrl_panel_model_inst.press(1'b0);
        chk({last_kp, 15'(n_rst)}, 16'h8004);
        @(posedge clk) running <= 1'b1;
        drrl_panel_model_inst.press(1'b0);
        chk(16'(n_rst * 16 + n_stop), 16'h0041);
        drrl_panel_model_inst.press(1'b1);
        chk(16'(n_rst * 16 + n_stop), 16'h0051);
        wr_reg(OFS_CTRL, 16'h0007);
        drrl_panel_model_inst.press(1'b0);
        chk(16'(n_rst * 16 + n_stop), 16'h0061);
        @(posedge clk) running <= 1'b0;
        core(1'b1, 1'b1);
        // An active run forward input keeps the latch and lets the restart happen.
        drrl_panel_model_inst.set_pins(1'b1, 1'b0, 4'h0);
        drrl_panel_model_inst.press(1'b0);
        chk({tripped, run_l, 14'(n_ar)}, 16'h4002);
        // An active run reverse input must block the latch clear just the same.
        core(1'b1, 1'b0);
        drrl_panel_model_inst.set_pins(1'b0, 1'b1, 4'h0);
        drrl_panel_model_inst.press(1'b0);
        chk({tripped, run_l, 14'(n_ar)}, 16'h4003);
        core(1'b1, 1'b0);
        drrl_panel_model_inst.set_pins(1'b0, 1'b0, 4'h0);
        drrl_panel_model_inst.press(1'b0);
        chk({tripped, run_l, 14'(n_ar)}, 16'h0003);
        rd_reg(OFS_IRQ_STAT, 16'h0007);
        wrap_up();
    end
endmodule
